// File: hw/ppfc_top.v
`timescale 1ns/1ps
`include "ppfc_map.vh"
module ppfc_top (
    input wire mclk,
    input wire nrst,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    output reg [7:0] rdata,
    input wire [7:0] port1_latch,
    input wire [7:0] port3_latch,
    input wire first_pwm_wave,
    input wire second_pwm_wave,
    input wire third_pwm_wave,
    input wire timer2_overflow,
    input wire timer0_overflow,
    output reg [7:0] port1_out,
    output reg [7:0] port3_out,
    output reg [15:0] port3_mode,
    output reg [3:0] port3_analog_sel,
    output reg first_pwm_enable,
    output reg second_pwm_enable,
    output reg third_pwm_enable,
    output reg [1:0] third_pwm_clock_select,
    output reg [9:0] third_pwm_duty,
    output reg group0_high_sink_enable,
    output reg group1_high_sink_enable,
    output reg group2_high_sink_enable
);

reg [7:0] port3_mode_low;
reg [7:0] port3_mode_high;
reg [7:0] pin_function_control;
reg [7:0] third_pwm_control;
reg [7:0] third_pwm_duty_high;
reg half_sysclk_out;
reg timer2_toggle_out;
reg timer0_div64_out;
reg [4:0] t0_count;
reg [7:0] next_rdata;
reg [7:0] next_port1;
reg [7:0] next_port3;
wire [15:0] mode_all;
wire wr_mode_low;
wire wr_mode_high;
wire wr_pin_func;
wire wr_pwm3_ctrl;
wire wr_pwm3_duty_high;

assign mode_all = {port3_mode_high, port3_mode_low};

// Write decode; a strobe to any other address is dropped
assign wr_mode_low = wr && (addr == `PPFC_ADDR_P3_MODE_LOW);
assign wr_mode_high = wr && (addr == `PPFC_ADDR_P3_MODE_HIGH);
assign wr_pin_func = wr && (addr == `PPFC_ADDR_PIN_FUNC);
assign wr_pwm3_ctrl = wr && (addr == `PPFC_ADDR_PWM3_CTRL);
assign wr_pwm3_duty_high = wr && (addr == `PPFC_ADDR_PWM3_DUTY_HIGH);

// Register writes, one enable per register
always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        port3_mode_low <= `PPFC_RST_P3_MODE;
    end else if (wr_mode_low) begin
        port3_mode_low <= wdata;
    end
end

always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        port3_mode_high <= `PPFC_RST_P3_MODE;
    end else if (wr_mode_high) begin
        port3_mode_high <= wdata;
    end
end

always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        pin_function_control <= `PPFC_RST_PIN_FUNC;
    end else if (wr_pin_func) begin
        pin_function_control <= wdata;
    end
end

// Bits 7..5 are reserved: held at zero so they read back zero
always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        third_pwm_control <= `PPFC_RST_PWM3_CTRL;
    end else if (wr_pwm3_ctrl) begin
        third_pwm_control <= {3'h0, wdata[4:0]};
    end
end

always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        third_pwm_duty_high <= `PPFC_RST_PWM3_DUTY_HIGH;
    end else if (wr_pwm3_duty_high) begin
        third_pwm_duty_high <= wdata;
    end
end

// Read mux; unmapped addresses return zero
always @* begin
    case (addr)
        `PPFC_ADDR_P3_MODE_LOW: next_rdata = port3_mode_low;
        `PPFC_ADDR_P3_MODE_HIGH: next_rdata = port3_mode_high;
        `PPFC_ADDR_PIN_FUNC: next_rdata = pin_function_control;
        `PPFC_ADDR_PWM3_CTRL: next_rdata = third_pwm_control;
        `PPFC_ADDR_PWM3_DUTY_HIGH: next_rdata = third_pwm_duty_high;
        default: next_rdata = 8'h00;
    endcase
end

// Zero outside the read cycle, so a stale value never lingers on the bus
always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        rdata <= 8'h00;
    end else if (rd) begin
        rdata <= next_rdata;
    end else begin
        rdata <= 8'h00;
    end
end

// Derived clocks; timer overflows are same-domain one-cycle pulses
always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        half_sysclk_out <= 1'b0;
    end else begin
        half_sysclk_out <= ~half_sysclk_out;
    end
end

always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        timer2_toggle_out <= 1'b0;
    end else if (timer2_overflow) begin
        timer2_toggle_out <= ~timer2_toggle_out;
    end
end

// Toggle every 32 overflows gives a period of 64
always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        timer0_div64_out <= 1'b0;
        t0_count <= 5'h00;
    end else if (timer0_overflow) begin
        if (t0_count == `PPFC_T0_DIV_HALF) begin
            t0_count <= 5'h00;
            timer0_div64_out <= ~timer0_div64_out;
        end else begin
            t0_count <= t0_count + 5'h01;
        end
    end
end

// Pin routing overrides the port latch while enabled
always @* begin
    next_port1 = port1_latch;
    next_port3 = port3_latch;
    if (pin_function_control[`PPFC_BIT_TIMER2_OE]) begin
        next_port1[0] = timer2_toggle_out;
    end
    if (pin_function_control[`PPFC_BIT_FIRST_PWM_OE]) begin
        next_port1[2] = first_pwm_wave;
    end
    if (pin_function_control[`PPFC_BIT_SECOND_PWM_OE]) begin
        next_port1[3] = second_pwm_wave;
    end
    if (pin_function_control[`PPFC_BIT_HALF_SYSCLK_OE]) begin
        next_port1[4] = half_sysclk_out;
    end
    // Third PWM enable lives in its own control register
    if (third_pwm_control[`PPFC_BIT_THIRD_PWM_OE]) begin
        next_port1[6] = third_pwm_wave;
    end
    if (pin_function_control[`PPFC_BIT_TIMER0_OE]) begin
        next_port3[4] = timer0_div64_out;
    end
end

// Registered outputs; the pin path is one cycle late by design
genvar gi;
generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_analog
        always @(posedge mclk or negedge nrst) begin
            if (!nrst) begin
                port3_analog_sel[gi] <= 1'b0;
            end else begin
                port3_analog_sel[gi] <= (mode_all[2*gi+1:2*gi] == `PPFC_MODE_ANALOG);
            end
        end
    end
endgenerate

// Every output leaves a flip-flop, so enables and fields are copies
always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        port1_out <= 8'h00;
    end else begin
        port1_out <= next_port1;
    end
end

always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        port3_out <= 8'h00;
    end else begin
        port3_out <= next_port3;
    end
end

always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        port3_mode <= {`PPFC_RST_P3_MODE, `PPFC_RST_P3_MODE};
    end else begin
        port3_mode <= mode_all;
    end
end

always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        first_pwm_enable <= 1'b0;
    end else begin
        first_pwm_enable <= pin_function_control[`PPFC_BIT_FIRST_PWM_OE];
    end
end

always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        second_pwm_enable <= 1'b0;
    end else begin
        second_pwm_enable <= pin_function_control[`PPFC_BIT_SECOND_PWM_OE];
    end
end

always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        third_pwm_enable <= 1'b0;
    end else begin
        third_pwm_enable <= third_pwm_control[`PPFC_BIT_THIRD_PWM_OE];
    end
end

always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        third_pwm_clock_select <= `PPFC_RST_PWM3_CKS;
    end else begin
        third_pwm_clock_select <= third_pwm_control[`PPFC_CKS_MSB:`PPFC_CKS_LSB];
    end
end

always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        third_pwm_duty <= `PPFC_RST_PWM3_DUTY;
    end else begin
        third_pwm_duty <= {third_pwm_duty_high,
            third_pwm_control[`PPFC_DL_MSB:`PPFC_DL_LSB]};
    end
end

// High-sink groups come out of reset enabled
always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        group0_high_sink_enable <= `PPFC_RST_HSNK;
    end else begin
        group0_high_sink_enable <= pin_function_control[`PPFC_BIT_GROUP0_HSNK];
    end
end

always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        group1_high_sink_enable <= `PPFC_RST_HSNK;
    end else begin
        group1_high_sink_enable <= pin_function_control[`PPFC_BIT_GROUP1_HSNK];
    end
end

always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        group2_high_sink_enable <= `PPFC_RST_HSNK;
    end else begin
        group2_high_sink_enable <= pin_function_control[`PPFC_BIT_GROUP2_HSNK];
    end
end

endmodule // ppfc_top

// File: hw/ppfc_map.vh
`ifndef PPFC_MAP_VH
`define PPFC_MAP_VH
// Register addresses
`define PPFC_ADDR_P3_MODE_LOW 8'ha4
`define PPFC_ADDR_P3_MODE_HIGH 8'ha5
`define PPFC_ADDR_PIN_FUNC 8'ha6
`define PPFC_ADDR_PWM3_CTRL 8'ha7
`define PPFC_ADDR_PWM3_DUTY_HIGH 8'h9f
// Reset values
`define PPFC_RST_P3_MODE 8'h55
`define PPFC_RST_PIN_FUNC 8'h0e
`define PPFC_RST_PWM3_CTRL 8'h08
`define PPFC_RST_PWM3_DUTY_HIGH 8'h80
`define PPFC_RST_PWM3_CKS 2'h2
`define PPFC_RST_PWM3_DUTY 10'h200
`define PPFC_RST_HSNK 1'b1
// Pin function bit positions
`define PPFC_BIT_SECOND_PWM_OE 7
`define PPFC_BIT_FIRST_PWM_OE 6
`define PPFC_BIT_HALF_SYSCLK_OE 5
`define PPFC_BIT_TIMER2_OE 4
`define PPFC_BIT_GROUP2_HSNK 3
`define PPFC_BIT_GROUP1_HSNK 2
`define PPFC_BIT_GROUP0_HSNK 1
`define PPFC_BIT_TIMER0_OE 0
// Third PWM control fields
`define PPFC_BIT_THIRD_PWM_OE 4
`define PPFC_CKS_MSB 3
`define PPFC_CKS_LSB 2
`define PPFC_DL_MSB 1
`define PPFC_DL_LSB 0
// Mode codes and timer0 divider
`define PPFC_MODE_ANALOG 2'h3
`define PPFC_T0_DIV_HALF 5'h1f
`endif

// File: tb/ppfc_checker.sv
`timescale 1ns/1ps
module ppfc_chk (
    input wire mclk,
    input wire nrst,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    input wire [7:0] rdata,
    input wire [7:0] port1_latch,
    input wire first_pwm_wave,
    input wire second_pwm_wave,
    input wire third_pwm_wave,
    input wire [7:0] port1_out,
    input wire [15:0] port3_mode,
    input wire [3:0] port3_analog_sel,
    input wire first_pwm_enable,
    input wire second_pwm_enable,
    input wire third_pwm_enable,
    input wire [9:0] third_pwm_duty,
    input wire group0_high_sink_enable,
    input wire group1_high_sink_enable,
    input wire group2_high_sink_enable
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    property p_pwm2; second_pwm_enable |-> port1_out[3] == $past(second_pwm_wave); endproperty
    a_pwm2: assert property (p_pwm2) else $error("second pwm not on pin");
    property p_pwm1; first_pwm_enable |-> port1_out[2] == $past(first_pwm_wave); endproperty
    a_pwm1: assert property (p_pwm1) else $error("first pwm not on pin");
    property p_pwm3; third_pwm_enable |-> port1_out[6] == $past(third_pwm_wave); endproperty
    a_pwm3: assert property (p_pwm3) else $error("third pwm not on pin");
    // Reset cycle excluded: pins hold 0 then, not the latch
    property p_latch; $past(nrst) && !second_pwm_enable |-> port1_out[3] == $past(port1_latch[3]);
    endproperty
    a_latch: assert property (p_latch) else $error("latch not on pin");
    property p_asel; port3_analog_sel == {port3_mode[7:6] == 2'h3, port3_mode[5:4] == 2'h3,
        port3_mode[3:2] == 2'h3, port3_mode[1:0] == 2'h3}; endproperty
    a_asel: assert property (p_asel) else $error("analog select wrong");
    property p_rsv; rd && addr == 8'ha7 |=> rdata[7:5] == 3'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits read nonzero");
    property p_duty; wr && addr == 8'h9f |-> ##2 third_pwm_duty[9:2] == $past(wdata, 2); endproperty
    a_duty: assert property (p_duty) else $error("duty high wrong");
    property p_mode; wr && addr == 8'ha4 |-> ##2 port3_mode[7:0] == $past(wdata, 2); endproperty
    a_mode: assert property (p_mode) else $error("low mode wrong");
    property p_hs; wr && addr == 8'ha6 |-> ##2 {group2_high_sink_enable, group1_high_sink_enable,
        group0_high_sink_enable} == $past(wdata[3:1], 2); endproperty
    a_hs: assert property (p_hs) else $error("high sink wrong");
endmodule // ppfc_chk
bind ppfc_top ppfc_chk u_chk (.*);

// File: tb/tb.sv
`timescale 1ns/1ps
module tb;
    reg mclk = 0, nrst = 0, wr = 0, rd = 0, w1 = 1, w2 = 1, w3 = 1, t2 = 0, t0 = 0, b, c;
    reg [7:0] addr = 0, wdata = 0, l1 = 0, l3 = 0;
    wire [7:0] rdata, p1, p3;
    wire [15:0] mode;
    wire [3:0] asel;
    wire e1, e2, e3, g0, g1, g2;
    wire [1:0] cks;
    wire [9:0] duty;
    integer mismatches = 0, total_checks = 0, i, n0, n2;
    ppfc_top dut (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .port1_latch(l1), .port3_latch(l3), .first_pwm_wave(w1),
        .second_pwm_wave(w2), .third_pwm_wave(w3), .timer2_overflow(t2), .timer0_overflow(t0),
        .port1_out(p1), .port3_out(p3), .port3_mode(mode), .port3_analog_sel(asel),
        .first_pwm_enable(e1), .second_pwm_enable(e2), .third_pwm_enable(e3),
        .third_pwm_clock_select(cks), .third_pwm_duty(duty), .group0_high_sink_enable(g0),
        .group1_high_sink_enable(g1), .group2_high_sink_enable(g2));
    initial forever #4 mclk = ~mclk;
    task chk(input [47:0] nm, input [15:0] seen, input [15:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("BAD %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task wreg(input [7:0] a, input [7:0] d);
        begin
            @(posedge mclk);
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge mclk);
            wr <= 1'b0;
        end
    endtask
    // Read data stands only in the cycle after the strobe
    task rchk(input [7:0] a, input [7:0] exp);
        begin
            @(posedge mclk);
            addr <= a;
            rd <= 1'b1;
            @(posedge mclk);
            rd <= 1'b0;
            @(negedge mclk);
            chk("rdata", rdata, exp);
        end
    endtask
    task settle;
        begin
            @(posedge mclk);
            @(negedge mclk);
        end
    endtask
    task t_rst;
        begin
            rchk(8'ha4, 8'h55);
            rchk(8'ha5, 8'h55);
            rchk(8'ha6, 8'h0e);
            rchk(8'ha7, 8'h08);
            rchk(8'h9f, 8'h80);
            rchk(8'h00, 8'h00);
            chk("duty", duty, 10'h200);
            chk("hsink", {g2, g1, g0}, 3'h7);
            chk("cks", cks, 2'h2);
        end
    endtask
    task t_mode;
        begin
            wreg(8'ha4, 8'he4);
            wreg(8'ha5, 8'hff);
            settle;
            chk("mode", mode, 16'hffe4);
            chk("asel", asel, 4'h8);
            rchk(8'ha4, 8'he4);
        end
    endtask
    task t_route;
        begin
            wreg(8'ha6, 8'hf1);
            settle;
            chk("en", {e2, e1}, 2'h3);
            chk("hsink", {g2, g1, g0}, 3'h0);
            chk("pwm", p1[3:2], 2'h3);
            @(posedge mclk);
            w1 <= 1'b0;
            settle;
            chk("pwm", p1[3:2], 2'h2);
            b = p1[4];
            @(negedge mclk);
            chk("ck", p1[4], !b);
            b = p1[0];
            c = p3[4];
            n0 = 0;
            n2 = 0;
            for (i = 0; i < 130; i = i + 1) begin
                @(posedge mclk);
                t0 <= i < 128 && !i[0];
                t2 <= i < 128 && !i[0];
                @(negedge mclk);
                n2 = n2 + (p1[0] !== b);
                b = p1[0];
                n0 = n0 + (p3[4] !== c);
                c = p3[4];
            end
            chk("t2", n2, 64);
            chk("t0", n0, 2);
            @(posedge mclk);
            l1 <= 8'h5a;
            l3 <= 8'ha5;
            wreg(8'ha6, 8'h0a);
            settle;
            chk("hsink", {g2, g1, g0}, 3'h5);
            chk("p1", p1, 8'h5a);
            chk("p3", p3, 8'ha5);
        end
    endtask
    task t_pwm3;
        begin
            wreg(8'h9f, 8'h3c);
            wreg(8'ha7, 8'hff);
            settle;
            chk("duty", duty, 10'h0f3);
            chk("pwm3", {e3, p1[6]}, 2'h3);
            rchk(8'ha7, 8'h1f);
            for (i = 0; i < 4; i = i + 1) begin
                wreg(8'ha7, {4'h0, i[1:0], 2'h0});
                settle;
                chk("cks", cks, i[1:0]);
            end
        end
    endtask
    task give_verdict;
        begin
            $display("checks %0d mismatches %0d", total_checks, mismatches);
            if (mismatches == 0 && total_checks > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
        t_rst;
        t_mode;
        t_route;
        t_pwm3;
        give_verdict;
    end
    initial begin
        #100000;
        mismatches = mismatches + 1;
        give_verdict;
    end
endmodule // tb
